/* File: rtl/msq_defines.svh */
// Offsets, field positions, reset values and sizes of the microsequencer
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH

// ==============================
// Register offsets (byte addresses)
`define MSQ_OFS_STATUS 8'h00
`define MSQ_OFS_IRQ_ENABLE 8'h04
`define MSQ_OFS_IRQ_CLEAR 8'h08
`define MSQ_OFS_ADDR 8'h0C
`define MSQ_OFS_COUNT 8'h10
`define MSQ_OFS_STACK 8'h14

// ==============================
// Status, clear and enable bit positions
`define MSQ_BIT_CARRY 0
`define MSQ_BIT_WARN 1
`define MSQ_BIT_STKERR 2
`define MSQ_BIT_ZERO 3
`define MSQ_EVENT_W 4

// ==============================
// Reset values and sizes
`define MSQ_RST_WORD 16'h0000
`define MSQ_RST_EVENTS 4'h0
`define MSQ_RST_SP 7'h00
`define MSQ_STACK_DEPTH 7'h41
`define MSQ_STACK_WARN 7'h3E
`define MSQ_ADDR_MAX 16'hFFFF
`define MSQ_RESP_OKAY 2'h0
`define MSQ_RESP_SLVERR 2'h2

`endif

/* File: rtl/msq_pkg.sv */
// Types shared by the microsequencer files
package msq_pkg;

	// ==============================
	// Address multiplexer sources
	typedef enum logic [2:0] {
		MSQ_Y_MPC = 3'h0,
		MSQ_Y_PORT_A = 3'h1,
		MSQ_Y_PORT_B = 3'h2,
		MSQ_Y_MW_A = 3'h3,
		MSQ_Y_MW_B = 3'h4,
		MSQ_Y_STACK = 3'h5,
		MSQ_Y_RCA = 3'h6,
		MSQ_Y_COND_A = 3'h7
	} msq_mux_type;

	// ==============================
	// Register/counter operations
	typedef enum logic [2:0] {
		MSQ_RC_HOLD = 3'h0,
		MSQ_RC_LOAD_A = 3'h1,
		MSQ_RC_LOAD_B = 3'h2,
		MSQ_RC_DEC_A = 3'h3,
		MSQ_RC_DEC_B = 3'h4,
		MSQ_RC_DEC_AB = 3'h5,
		MSQ_RC_LOAD_AB = 3'h6,
		MSQ_RC_CLEAR = 3'h7
	} msq_rc_type;

	// ==============================
	// Stack operations
	typedef enum logic [2:0] {
		MSQ_ST_HOLD = 3'h0,
		MSQ_ST_PUSH_MPC = 3'h1,
		MSQ_ST_PUSH_A = 3'h2,
		MSQ_ST_POP = 3'h3,
		MSQ_ST_CLEAR = 3'h4
	} msq_st_type;

	// ==============================
	// Write channel state, Gray along collect to respond
	typedef enum logic [1:0] {
		MSQ_WR_COLLECT = 2'h0,
		MSQ_WR_RESP = 2'h1
	} msq_wr_state_type;

	// ==============================
	// Control pins from the pipeline register
	typedef struct packed {
		msq_mux_type addr_mux_ctl;
		msq_rc_type counter_ctl;
		msq_st_type stack_ctl;
		logic incr_ctl;
		logic cond_code_in;
		logic irq_select_n;
		logic irq_ret_load_n;
		logic port_a_src_sel;
		logic port_data_src_sel;
		logic zero_force_in;
		logic port_a_oe_n;
		logic port_b_oe_n;
		logic addr_out_oe_n;
		logic [3:0] branch_bits;
	} msq_ctl_type;

endpackage : msq_pkg

/* File: rtl/msq_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module msq_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_dout;

	// Bit takes the new level only once stages two and three agree
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			dout <= '0;
		end
		else
		begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
			dout <= next_dout;
		end
	end
endmodule : msq_sync

/* File: rtl/msq_top.sv */
// Microprogram sequencer core with pin control and AXI4-Lite status block
// Functional notes
// - Carry-out rises when incrementing the program counter passes the top address.
// - Port A drives stack or counter A while its enable is low and data source select is low, the address when it is high.
// - Port B drives counter B while its enable is low and data source select is low, the address when it is high.
// - Port A source: counter A when select low, stack top when high.
// - Return register holds while its enable is high, loads address when low.
// - Interrupt select low makes the return register the pushed value.
// - Branch bits take part in multiway branch address forming.
// - Three mux control bits choose the address output source.
// - Data source select decides what feeds both bidirectional ports.
// - Counter control picks counter operations; stack control picks stack operations.
// - Stack warning flag provided; increment control and condition code steer sequencing.
// - Multiway address keeps upper twelve port bits, low four from branch bits.
// - Address bus driven only while its enable is low, else floats.
// - Zero force makes zero detect high; zero detect reported on its output.
`timescale 1ns/1ps
`include "msq_defines.svh"
module msq_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire msq_pkg::msq_ctl_type ctl,
	input wire logic [15:0] port_a_in,
	output logic [15:0] port_a_out,
	output logic port_a_oe,
	input wire logic [15:0] port_b_in,
	output logic [15:0] port_b_out,
	output logic port_b_oe,
	input wire logic [15:0] addr_y_in,
	output logic [15:0] addr_y_out,
	output logic addr_y_oe,
	output logic incr_carry_out,
	output logic stack_warn_flag,
	output logic zero_detect_out,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int SYNC_W = $bits(msq_pkg::msq_ctl_type) + 48;

	// ==============================
	// Pin synchronisers
	msq_pkg::msq_ctl_type c;
	logic [15:0] pa_pin;
	logic [15:0] pb_pin;
	logic [15:0] y_pin;
	logic [SYNC_W-1:0] sync_out;

	msq_sync #(.WIDTH(SYNC_W)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({ctl, port_a_in, port_b_in, addr_y_in}),
		.dout(sync_out)
	);
	assign {c, pa_pin, pb_pin, y_pin} = sync_out;

	// ==============================
	// Sequencer datapath
	logic [15:0] micro_pc;
	logic [15:0] reg_counter_a;
	logic [15:0] reg_counter_b;
	logic [15:0] irq_return_reg;
	logic [15:0] stack_mem [0:64];
	logic [6:0] sp;
	logic stack_err;
	logic [15:0] next_micro_pc, next_rca, next_rcb, next_irq_ret;
	logic [15:0] next_addr, next_port_a, next_port_b, next_push_val;
	logic [6:0] next_sp;
	logic next_stack_err, next_carry, next_warn, next_zero, push_en;
	logic [15:0] y_cur, port_a_bus, port_b_bus, stack_top;

	assign stack_top = (sp == 7'h00) ? `MSQ_RST_WORD : stack_mem[sp - 7'h01];
	// Floating address bus takes the externally forced vector
	assign y_cur = c.addr_out_oe_n ? y_pin : addr_y_out;
	// Own driven value is used while driving, pin only when released
	assign port_a_bus = c.port_a_oe_n ? pa_pin : port_a_out;
	assign port_b_bus = c.port_b_oe_n ? pb_pin : port_b_out;
	assign port_a_oe = !c.port_a_oe_n;
	assign port_b_oe = !c.port_b_oe_n;
	assign addr_y_oe = !c.addr_out_oe_n;

	always_comb
	begin
		// Port drive sources
		if (c.port_data_src_sel)
		begin
			next_port_a = y_cur;
			next_port_b = y_cur;
		end
		else
		begin
			next_port_a = c.port_a_src_sel ? stack_top : reg_counter_a;
			next_port_b = reg_counter_b;
		end
		// Address output source
		case (c.addr_mux_ctl)
			msq_pkg::MSQ_Y_MPC: next_addr = micro_pc;
			msq_pkg::MSQ_Y_PORT_A: next_addr = port_a_bus;
			msq_pkg::MSQ_Y_PORT_B: next_addr = port_b_bus;
			msq_pkg::MSQ_Y_MW_A: next_addr = {port_a_bus[15:4], c.branch_bits};
			msq_pkg::MSQ_Y_MW_B: next_addr = {port_b_bus[15:4], c.branch_bits};
			msq_pkg::MSQ_Y_STACK: next_addr = stack_top;
			msq_pkg::MSQ_Y_RCA: next_addr = reg_counter_a;
			msq_pkg::MSQ_Y_COND_A: next_addr = c.cond_code_in ? port_a_bus : micro_pc;
			default: next_addr = micro_pc;
		endcase
		// Incrementer
		next_micro_pc = c.incr_ctl ? y_cur + 16'h0001 : y_cur;
		next_carry = c.incr_ctl && (y_cur == `MSQ_ADDR_MAX);
		next_irq_ret = c.irq_ret_load_n ? irq_return_reg : y_cur;
		// Register/counters
		next_rca = reg_counter_a;
		next_rcb = reg_counter_b;
		case (c.counter_ctl)
			msq_pkg::MSQ_RC_HOLD: next_rca = reg_counter_a;
			msq_pkg::MSQ_RC_LOAD_A: next_rca = port_a_bus;
			msq_pkg::MSQ_RC_LOAD_B: next_rcb = port_b_bus;
			msq_pkg::MSQ_RC_DEC_A: next_rca = reg_counter_a - 16'h0001;
			msq_pkg::MSQ_RC_DEC_B: next_rcb = reg_counter_b - 16'h0001;
			msq_pkg::MSQ_RC_DEC_AB:
			begin
				next_rca = reg_counter_a - 16'h0001;
				next_rcb = reg_counter_b - 16'h0001;
			end
			msq_pkg::MSQ_RC_LOAD_AB:
			begin
				next_rca = port_a_bus;
				next_rcb = port_b_bus;
			end
			msq_pkg::MSQ_RC_CLEAR:
			begin
				next_rca = `MSQ_RST_WORD;
				next_rcb = `MSQ_RST_WORD;
			end
			default: next_rca = reg_counter_a;
		endcase
		// Stack; overflow and underflow leave the pointer and set the error
		push_en = 1'b0;
		next_sp = sp;
		next_stack_err = stack_err;
		next_push_val = !c.irq_select_n ? irq_return_reg :
			((c.stack_ctl == msq_pkg::MSQ_ST_PUSH_A) ? port_a_bus : micro_pc);
		case (c.stack_ctl)
			msq_pkg::MSQ_ST_PUSH_MPC, msq_pkg::MSQ_ST_PUSH_A:
			begin
				if (sp < `MSQ_STACK_DEPTH)
				begin
					push_en = 1'b1;
					next_sp = sp + 7'h01;
				end
				else
				begin
					next_stack_err = 1'b1;
				end
			end
			msq_pkg::MSQ_ST_POP:
			begin
				if (sp != 7'h00)
				begin
					next_sp = sp - 7'h01;
				end
				else
				begin
					next_stack_err = 1'b1;
				end
			end
			msq_pkg::MSQ_ST_CLEAR:
			begin
				next_sp = `MSQ_RST_SP;
				next_stack_err = 1'b0;
			end
			default: next_sp = sp;
		endcase
		next_warn = (next_sp >= `MSQ_STACK_WARN) || next_stack_err;
		next_zero = c.zero_force_in || (next_rca == `MSQ_RST_WORD);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			micro_pc <= `MSQ_RST_WORD;
			reg_counter_a <= `MSQ_RST_WORD;
			reg_counter_b <= `MSQ_RST_WORD;
			irq_return_reg <= `MSQ_RST_WORD;
			addr_y_out <= `MSQ_RST_WORD;
			port_a_out <= `MSQ_RST_WORD;
			port_b_out <= `MSQ_RST_WORD;
			sp <= `MSQ_RST_SP;
			stack_err <= 1'b0;
			incr_carry_out <= 1'b0;
			stack_warn_flag <= 1'b0;
			zero_detect_out <= 1'b0;
		end
		else
		begin
			micro_pc <= next_micro_pc;
			reg_counter_a <= next_rca;
			reg_counter_b <= next_rcb;
			irq_return_reg <= next_irq_ret;
			addr_y_out <= next_addr;
			port_a_out <= next_port_a;
			port_b_out <= next_port_b;
			sp <= next_sp;
			stack_err <= next_stack_err;
			incr_carry_out <= next_carry;
			stack_warn_flag <= next_warn;
			zero_detect_out <= next_zero;
		end
	end

	// Stack storage has no reset; the pointer alone defines contents
	always_ff @(posedge aclk)
	begin
		if (push_en)
		begin
			stack_mem[sp] <= next_push_val;
		end
	end

	// ==============================
	// Event status and interrupt
	logic [3:0] irq_status, irq_enable, next_status, next_enable, events, clr_mask;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	assign events = {zero_detect_out, stack_err, stack_warn_flag, incr_carry_out};
	assign irq = |(irq_status & irq_enable);

	always_comb
	begin
		clr_mask = 4'h0;
		next_enable = irq_enable;
		if (wr_fire && wr_strb[0] && (wr_addr == `MSQ_OFS_IRQ_CLEAR))
		begin
			clr_mask = wr_data[3:0];
		end
		if (wr_fire && wr_strb[0] && (wr_addr == `MSQ_OFS_IRQ_ENABLE))
		begin
			next_enable = wr_data[3:0];
		end
		// A new event wins over a clear in the same cycle
		next_status = (irq_status & ~clr_mask) | events;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status <= `MSQ_RST_EVENTS;
			irq_enable <= `MSQ_RST_EVENTS;
		end
		else
		begin
			irq_status <= next_status;
			irq_enable <= next_enable;
		end
	end

	// ==============================
	// AXI4-Lite slave
	msq_pkg::msq_wr_state_type wr_state, next_wr_state;
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] next_wr_addr;
	logic [31:0] next_wr_data;
	logic [3:0] next_wr_strb;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	assign s_axi_awready = !aw_held && (wr_state == msq_pkg::MSQ_WR_COLLECT);
	assign s_axi_wready = !w_held && (wr_state == msq_pkg::MSQ_WR_COLLECT);
	assign s_axi_bvalid = (wr_state == msq_pkg::MSQ_WR_RESP);
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_held && w_held && (wr_state == msq_pkg::MSQ_WR_COLLECT);

	always_comb
	begin
		next_wr_state = wr_state;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_bresp = s_axi_bresp;
		case (wr_state)
			msq_pkg::MSQ_WR_COLLECT:
			begin
				if (s_axi_awvalid && s_axi_awready)
				begin
					next_aw_held = 1'b1;
					next_wr_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready)
				begin
					next_w_held = 1'b1;
					next_wr_data = s_axi_wdata;
					next_wr_strb = s_axi_wstrb;
				end
				if (wr_fire)
				begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					next_wr_state = msq_pkg::MSQ_WR_RESP;
					next_bresp = ((wr_addr == `MSQ_OFS_IRQ_ENABLE) ||
						(wr_addr == `MSQ_OFS_IRQ_CLEAR)) ? `MSQ_RESP_OKAY : `MSQ_RESP_SLVERR;
				end
			end
			msq_pkg::MSQ_WR_RESP:
			begin
				if (s_axi_bready)
				begin
					next_wr_state = msq_pkg::MSQ_WR_COLLECT;
				end
			end
			default: next_wr_state = msq_pkg::MSQ_WR_COLLECT;
		endcase
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = `MSQ_RESP_OKAY;
			case (s_axi_araddr)
				`MSQ_OFS_STATUS: next_rdata = {28'h0000000, irq_status};
				`MSQ_OFS_IRQ_ENABLE: next_rdata = {28'h0000000, irq_enable};
				`MSQ_OFS_IRQ_CLEAR: next_rdata = 32'h00000000;
				`MSQ_OFS_ADDR: next_rdata = {micro_pc, addr_y_out};
				`MSQ_OFS_COUNT: next_rdata = {reg_counter_b, reg_counter_a};
				`MSQ_OFS_STACK: next_rdata = {25'h0, sp};
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = `MSQ_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state <= msq_pkg::MSQ_WR_COLLECT;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_bresp <= `MSQ_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MSQ_RESP_OKAY;
		end
		else
		begin
			wr_state <= next_wr_state;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// ==============================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_carry_at_top: assert property (c.incr_ctl && y_cur == 16'hFFFF |=> incr_carry_out)
		else $error("carry-out missing at top address");
	a_port_a_dir: assert property (!c.port_data_src_sel && c.port_a_src_sel
		|=> port_a_out == $past(stack_top))
		else $error("port A not stack top");
	a_port_b_data: assert property (!c.port_data_src_sel |=> port_b_out == $past(reg_counter_b))
		else $error("port B not counter B");
	a_port_a_source: assert property (!c.port_data_src_sel && !c.port_a_src_sel
		|=> port_a_out == $past(reg_counter_a))
		else $error("port A source wrong");
	a_ret_hold_load: assert property (!c.irq_ret_load_n |=> irq_return_reg == $past(y_cur))
		else $error("return register not loaded");
	a_ret_hold_keep: assert property (c.irq_ret_load_n |=> $stable(irq_return_reg))
		else $error("return register changed while held");
	a_push_irq_ret: assert property (!c.irq_select_n && push_en |=> stack_top == $past(irq_return_reg))
		else $error("interrupt return not pushed");
	a_multiway_low: assert property (c.addr_mux_ctl == msq_pkg::MSQ_Y_MW_B
		|=> addr_y_out == {$past(port_b_bus[15:4]), $past(c.branch_bits)})
		else $error("multiway address wrong");
	a_mux_mpc: assert property (c.addr_mux_ctl == msq_pkg::MSQ_Y_MPC |=> addr_y_out == $past(micro_pc))
		else $error("address mux not program counter");
	a_zero_force: assert property (c.zero_force_in |=> zero_detect_out)
		else $error("zero force ignored");
	a_irq_follows: assert property (|(events & irq_enable) |=> irq)
		else $error("enabled event gave no interrupt");

	c_multiway: cover property (c.addr_mux_ctl == msq_pkg::MSQ_Y_MW_A ##1 c.incr_ctl);
	c_push_pop: cover property (push_en ##[1:4] c.stack_ctl == msq_pkg::MSQ_ST_POP);
	c_irq_seen: cover property (!irq ##1 irq);
	c_axi_write: cover property (wr_fire ##1 s_axi_bvalid);
endmodule : msq_top

/* File: testbench/msq_far_side.sv */
// Far-side model: the external bus drivers and pin resolution
`timescale 1ns/1ps
module msq_far_side (
	input wire logic port_a_oe,
	input wire logic [15:0] port_a_out,
	input wire logic port_b_oe,
	input wire logic [15:0] port_b_out,
	input wire logic addr_y_oe,
	input wire logic [15:0] addr_y_out,
	input wire logic [15:0] ext_a,
	input wire logic [15:0] ext_b,
	input wire logic [15:0] ext_y,
	output logic [15:0] port_a_pin,
	output logic [15:0] port_b_pin,
	output logic [15:0] addr_y_pin
);
	// ==============================
	// Pin resolution
	// Outside logic backs off whenever the device drives, so no contention
	assign port_a_pin = port_a_oe ? port_a_out : ext_a;
	assign port_b_pin = port_b_oe ? port_b_out : ext_b;
	// Interrupt vector placed on the address bus only while it floats
	assign addr_y_pin = addr_y_oe ? addr_y_out : ext_y;
endmodule : msq_far_side

/* File: testbench/msq_top_tb.sv */
// Self-checking bench for the microsequencer core
`timescale 1ns/1ps
`include "msq_defines.svh"
module msq_top_tb;
	typedef struct {int kind; logic [31:0] exp;} msq_note_type;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	msq_pkg::msq_ctl_type ctl;
	logic [15:0] ext_a = 16'h0000;
	logic [15:0] ext_b = 16'h0000;
	logic [15:0] ext_y = 16'h0000;
	logic [15:0] pa_in, pb_in, y_in, pa_out, pb_out, y_out;
	logic pa_oe, pb_oe, y_oe, carry, warn, zero, irq;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	msq_note_type notes[$];
	int err_total = 0;
	int checks = 0;
	string names[8] = '{"rdata", "rresp", "bresp", "addr_y_out", "port_a_out", "port_b_out",
		"flags", "enables"};
	event pin_ev;

	always #5 aclk = ~aclk;

	msq_top i_dut (.aclk(aclk), .aresetn(aresetn), .ctl(ctl), .port_a_in(pa_in),
		.port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(pb_in), .port_b_out(pb_out),
		.port_b_oe(pb_oe), .addr_y_in(y_in), .addr_y_out(y_out), .addr_y_oe(y_oe),
		.incr_carry_out(carry), .stack_warn_flag(warn), .zero_detect_out(zero), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	msq_far_side i_far (.port_a_oe(pa_oe), .port_a_out(pa_out), .port_b_oe(pb_oe),
		.port_b_out(pb_out), .addr_y_oe(y_oe), .addr_y_out(y_out), .ext_a(ext_a),
		.ext_b(ext_b), .ext_y(ext_y), .port_a_pin(pa_in), .port_b_pin(pb_in),
		.addr_y_pin(y_in));

	// ==============================
	// Notes and comparison
	task expect_val(input int kind, input logic [31:0] exp);
		notes.push_back('{kind, exp});
	endtask : expect_val

	task compare_note(input logic [31:0] got);
		msq_note_type n;
		n = notes.pop_front();
		checks++;
		if (got !== n.exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", names[n.kind], n.exp, got);
		end
	endtask : compare_note

	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			compare_note(rdata);
			compare_note({30'h0, rresp});
		end
		if (bvalid && bready)
			compare_note({30'h0, bresp});
	end

	always @(pin_ev)
		case (notes[0].kind)
			3: compare_note({16'h0000, y_out});
			4: compare_note({16'h0000, pa_out});
			5: compare_note({16'h0000, pb_out});
			6: compare_note({28'h0000000, irq, zero, warn, carry});
			default: compare_note({29'h0, y_oe, pb_oe, pa_oe});
		endcase

	// ==============================
	// Drivers
	task settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle

	task pin_check(input int kind, input logic [31:0] exp);
		expect_val(kind, exp);
		#1;
		-> pin_ev;
		@(posedge aclk);
	endtask : pin_check

	task axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
		// Idle edge keeps the last release apart from this request
		@(posedge aclk);
		expect_val(2, {30'h0, resp});
		awaddr <= addr;
		wdata <= data;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				bready <= 1'b0;
		end
		while (!(bvalid && bready));
	endtask : axi_write

	task axi_read(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
		@(posedge aclk);
		expect_val(0, data);
		expect_val(1, {30'h0, resp});
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				rready <= 1'b0;
		end
		while (!(rvalid && rready));
	endtask : axi_read

	task end_of_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end

	// ==============================
	// Tests
	initial
	begin
		logic [15:0] ra, rb, rs, rv;
		logic [3:0] bb;
		logic [15:0] ymux [8];
		logic [2:0] order [8];
		rs = 16'($urandom(1828));
		ra = 16'($urandom()) | 16'h0001;
		rb = 16'($urandom());
		rv = 16'($urandom());
		bb = 4'($urandom());
		ctl = '0;
		ctl.port_a_oe_n = 1'b1;
		ctl.port_b_oe_n = 1'b1;
		ctl.irq_select_n = 1'b1;
		ctl.irq_ret_load_n = 1'b1;
		settle(6);
		aresetn <= 1'b1;
		axi_read(`MSQ_OFS_IRQ_ENABLE, 32'h00000000, `MSQ_RESP_OKAY);
		axi_read(8'h18, 32'h00000000, `MSQ_RESP_SLVERR);
		axi_write(8'h18, 32'h0000000F, `MSQ_RESP_SLVERR);
		axi_write(`MSQ_OFS_IRQ_ENABLE, 32'h00000001, `MSQ_RESP_OKAY);
		axi_read(`MSQ_OFS_IRQ_ENABLE, 32'h00000001, `MSQ_RESP_OKAY);
		axi_read(`MSQ_OFS_IRQ_CLEAR, 32'h00000000, `MSQ_RESP_OKAY);
		$display("registers done");
		ext_a <= rs;
		ctl.stack_ctl <= msq_pkg::MSQ_ST_PUSH_A;
		settle(8);
		ctl.stack_ctl <= msq_pkg::MSQ_ST_HOLD;
		ext_a <= ra;
		ext_b <= rb;
		ctl.branch_bits <= bb;
		ctl.cond_code_in <= 1'b1;
		ctl.counter_ctl <= msq_pkg::MSQ_RC_LOAD_AB;
		settle(8);
		ctl.counter_ctl <= msq_pkg::MSQ_RC_HOLD;
		// Code 0 follows 5 so the program counter holds the stack value
		ymux = '{rs, ra, rb, {ra[15:4], bb}, {rb[15:4], bb}, rs, ra, ra};
		order = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h6, 3'h7};
		for (int i = 0; i < 8; i++)
		begin
			ctl.addr_mux_ctl <= msq_pkg::msq_mux_type'(order[i]);
			settle(8);
			pin_check(3, {16'h0000, ymux[order[i]]});
		end
		ctl.port_a_oe_n <= 1'b0;
		ctl.port_b_oe_n <= 1'b0;
		settle(8);
		pin_check(7, 32'h00000007);
		pin_check(4, {16'h0000, ra});
		pin_check(5, {16'h0000, rb});
		ctl.port_a_src_sel <= 1'b1;
		ctl.addr_mux_ctl <= msq_pkg::MSQ_Y_RCA;
		ctl.port_data_src_sel <= 1'b1;
		settle(8);
		pin_check(5, {16'h0000, ra});
		ctl.port_data_src_sel <= 1'b0;
		settle(8);
		pin_check(4, {16'h0000, rs});
		$display("multiplexers done");
		ctl.port_a_oe_n <= 1'b1;
		ctl.addr_mux_ctl <= msq_pkg::MSQ_Y_PORT_A;
		ext_a <= rv;
		ctl.irq_ret_load_n <= 1'b0;
		settle(8);
		ctl.irq_ret_load_n <= 1'b1;
		ext_a <= ~rv;
		settle(8);
		ctl.irq_select_n <= 1'b0;
		ctl.stack_ctl <= msq_pkg::MSQ_ST_PUSH_MPC;
		settle(4);
		ctl.irq_select_n <= 1'b1;
		ctl.stack_ctl <= msq_pkg::MSQ_ST_HOLD;
		ctl.port_a_oe_n <= 1'b0;
		settle(8);
		pin_check(4, {16'h0000, rv});
		$display("return register done");
		ctl.port_a_oe_n <= 1'b1;
		settle(8);
		axi_write(`MSQ_OFS_IRQ_CLEAR, 32'h0000000F, `MSQ_RESP_OKAY);
		axi_read(`MSQ_OFS_STATUS, 32'h00000000, `MSQ_RESP_OKAY);
		ext_a <= 16'hFFFF;
		ctl.incr_ctl <= 1'b1;
		settle(8);
		pin_check(6, 32'h00000009);
		axi_write(`MSQ_OFS_IRQ_CLEAR, 32'h00000001, `MSQ_RESP_OKAY);
		axi_read(`MSQ_OFS_STATUS, 32'h00000001, `MSQ_RESP_OKAY);
		ext_a <= 16'h1234;
		settle(8);
		axi_write(`MSQ_OFS_IRQ_CLEAR, 32'h00000001, `MSQ_RESP_OKAY);
		pin_check(6, 32'h00000000);
		ctl.zero_force_in <= 1'b1;
		settle(8);
		pin_check(6, 32'h00000004);
		axi_read(`MSQ_OFS_STATUS, 32'h00000008, `MSQ_RESP_OKAY);
		// Overfill the stack: warning, then error once full
		ctl.stack_ctl <= msq_pkg::MSQ_ST_PUSH_MPC;
		settle(60);
		ctl.stack_ctl <= msq_pkg::MSQ_ST_HOLD;
		settle(8);
		pin_check(6, 32'h00000006);
		axi_read(`MSQ_OFS_STATUS, 32'h0000000E, `MSQ_RESP_OKAY);
		$display("flags done");
		// Released address bus takes the outside vector
		ctl.addr_out_oe_n <= 1'b1;
		ctl.addr_mux_ctl <= msq_pkg::MSQ_Y_MPC;
		ext_y <= rv;
		settle(16);
		pin_check(7, 32'h00000002);
		pin_check(3, {16'h0000, 16'(rv + 16'h0001)});
		$display("address release done");
		end_of_test();
	end
endmodule : msq_top_tb
